// [rsi_interlock.sv]
// Purpose: door, enabling device, pendant and key switch interlock with apb registers
// Assumes: contact inputs are 1 when closed; apb master keeps the standard protocol
// Notes: pready is always high, so every access ends in its first access cycle
//
// Summary of operation
// - auto door open: servo off, stop, error
// - teaching: open door alone never blocks servo
// - door open: enabling release cuts servo
// - door open, enabling released: refuse servo, brake
// - door open: servo/jog need both switches
// - door closed: pendant alone may servo on
// - manual jog with enabling closed, any door
// - manual jog, enabling open, needs door closed
// - brake release: manual, pendant, switches, door ignored
// - auto run: auto, pendant off, door closed
// - brake needs both switches at middle position
// - auto: external rights, pendant commands refused
// - manual with pendant: pendant rights only
// - external rights also need configuration bit
// - keys both open manual, both closed auto
// - keys disagree: keep previous mode
//
// Our own choices: the address map and register access over APB.
`include "rsi_map.svh"

module rsi_interlock #(
   parameter int P_FILT_CYC = `RSI_FILT_CYC
)(
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic I_DOOR_CLOSED,
   input wire logic I_ENDEV_CLOSED,
   input wire logic I_PEND_SW_ON,
   input wire logic I_PEND_ACTIVE,
   input wire logic I_KEY1_CLOSED,
   input wire logic I_KEY2_CLOSED,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [7:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   output logic O_SERVO_ON,
   output logic O_BRAKE_REL,
   output logic O_JOG_EN,
   output logic O_RUN,
   output logic O_ERROR,
   output logic O_MODE_AUTO,
   output logic O_RIGHTS_EXT,
   output logic O_RIGHTS_PEND
);

   // ----------------------------------------
   // reset release
   // ----------------------------------------
   logic rst_q1;
   logic rst_n;

   always_ff @(posedge I_CLK_SYS or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end
      else
      begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // ----------------------------------------
   // switch conditioning
   // ----------------------------------------
   rsi_pkg::rsi_sw_t raw;
   rsi_pkg::rsi_sw_t sw;
   logic [5:0] flt;

   assign raw = '{key2: I_KEY2_CLOSED, key1: I_KEY1_CLOSED, pend_act: I_PEND_ACTIVE,
                  pend_sw: I_PEND_SW_ON, endev: I_ENDEV_CLOSED, door: I_DOOR_CLOSED};

   rsi_filter #(
      .N(6),
      .CNT(P_FILT_CYC)
   ) u_filter (
      .i_clk(I_CLK_SYS),
      .i_rst_n(rst_n),
      .i_raw(raw),
      .o_flt(flt)
   );

   assign sw = rsi_pkg::rsi_sw_t'(flt);

   // ----------------------------------------
   // operating mode
   // ----------------------------------------
   logic mode_auto;

   always_ff @(posedge I_CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
         mode_auto <= 1'b0;
      else if (sw.key1 && sw.key2)
         mode_auto <= 1'b1;
      else if (!sw.key1 && !sw.key2)
         mode_auto <= 1'b0;
      // disagreeing keys leave the mode alone
   end

   // ----------------------------------------
   // apb slave
   // ----------------------------------------
   logic [2:0] ctrl;
   logic [1:0] flag;
   logic setup;
   logic wr;
   logic hit;
   logic cmd_we;
   logic [5:0] cmd;
   rsi_pkg::rsi_state_t state;
   rsi_pkg::rsi_state_t next_state;
   rsi_pkg::rsi_stat_t stat;
   logic brake_rel;
   logic jog_en;

   assign setup = I_PSEL && !I_PENABLE;
   assign wr = I_PSEL && I_PENABLE && I_PWRITE;
   assign hit = (I_PADDR == `RSI_OFF_CTRL) || (I_PADDR == `RSI_OFF_CMD) ||
                (I_PADDR == `RSI_OFF_STAT) || (I_PADDR == `RSI_OFF_FLAG);
   assign cmd_we = wr && (I_PADDR == `RSI_OFF_CMD);
   assign cmd = cmd_we ? I_PWDATA[5:0] : 6'h00;
   assign O_PREADY = 1'b1;
   assign O_PSLVERR = I_PSEL && I_PENABLE && !hit;

   always_ff @(posedge I_CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctrl <= `RSI_CTRL_RST;
      end
      else if (wr && (I_PADDR == `RSI_OFF_CTRL))
      begin
         ctrl <= I_PWDATA[2:0];
      end
   end

   assign stat = '{zero: 20'h00000, sw: sw, brake: brake_rel, jog: jog_en,
                   err: (state == rsi_pkg::ST_FAULT), auto_mode: mode_auto, state: state};

   // read data is captured in the setup cycle and stands through the access cycle
   always_ff @(posedge I_CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         O_PRDATA <= 32'h00000000;
      end
      else if (setup && !I_PWRITE)
      begin
         case (I_PADDR)
            `RSI_OFF_CTRL: O_PRDATA <= {29'h00000000, ctrl};
            `RSI_OFF_STAT: O_PRDATA <= stat;
            `RSI_OFF_FLAG: O_PRDATA <= {30'h00000000, flag};
            default: O_PRDATA <= 32'h00000000;
         endcase
      end
   end

   // ----------------------------------------
   // operation rights and permits
   // ----------------------------------------
   logic rights_ext;
   logic rights_pend;
   logic acc;
   logic man_ok;
   logic permit;
   logic door_trip;
   logic rej;

   assign rights_ext = mode_auto && ctrl[`RSI_CTRL_EXT];
   assign rights_pend = !mode_auto && sw.pend_act;
   assign acc = cmd[`RSI_CMD_SRC] ? rights_ext : rights_pend;

   // door open needs the enabling device too; door closed lets the pendant act alone
   assign man_ok = !mode_auto && sw.pend_act && sw.pend_sw &&
                   (sw.endev || sw.door);
   assign permit = mode_auto ? (!sw.pend_act && sw.door) : man_ok;
   assign door_trip = mode_auto && !sw.door &&
                      ((state == rsi_pkg::ST_SERVO) || (state == rsi_pkg::ST_RUN));

   // ----------------------------------------
   // servo and run sequencing
   // ----------------------------------------
   always_comb
   begin
      next_state = state;
      rej = cmd_we && !acc;
      case (state)
         rsi_pkg::ST_OFF:
         begin
            if (cmd[`RSI_CMD_SON] && acc && permit)
               next_state = rsi_pkg::ST_SERVO;
            else if (cmd[`RSI_CMD_SON] && acc)
               rej = 1'b1;
         end
         rsi_pkg::ST_SERVO:
         begin
            if (door_trip)
               next_state = rsi_pkg::ST_FAULT;
            else if (!permit)
               next_state = rsi_pkg::ST_OFF;
            else if (acc && cmd[`RSI_CMD_SOFF])
               next_state = rsi_pkg::ST_OFF;
            else if (acc && cmd[`RSI_CMD_START] && mode_auto)
               next_state = rsi_pkg::ST_RUN;
         end
         rsi_pkg::ST_RUN:
         begin
            if (door_trip)
               next_state = rsi_pkg::ST_FAULT;
            else if (!permit || !mode_auto)
               next_state = rsi_pkg::ST_OFF;
            else if (acc && cmd[`RSI_CMD_SOFF])
               next_state = rsi_pkg::ST_OFF;
            else if (acc && cmd[`RSI_CMD_STOP])
               next_state = rsi_pkg::ST_SERVO;
         end
         rsi_pkg::ST_FAULT:
         begin
            // alarm clears only with the door shut; servo-on and start follow separately
            if (acc && cmd[`RSI_CMD_ARST] && sw.door)
               next_state = rsi_pkg::ST_OFF;
            else if (acc && cmd[`RSI_CMD_ARST])
               rej = 1'b1;
         end
         default:
            next_state = rsi_pkg::ST_OFF;
      endcase
   end

   always_ff @(posedge I_CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= rsi_pkg::ST_OFF;
      end
      else
      begin
         state <= next_state;
      end
   end

   // ----------------------------------------
   // jog and brake permissions
   // ----------------------------------------
   always_ff @(posedge I_CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         jog_en <= 1'b0;
         brake_rel <= 1'b0;
      end
      else
      begin
         jog_en <= ctrl[`RSI_CTRL_JOG] && (next_state == rsi_pkg::ST_SERVO) &&
                   man_ok;
         // both switches at the middle position; door is not looked at
         brake_rel <= ctrl[`RSI_CTRL_BRK] && !mode_auto && sw.pend_act &&
                      sw.pend_sw && sw.endev;
      end
   end

   // ----------------------------------------
   // sticky flags, write one to clear
   // ----------------------------------------
   logic [1:0] flag_set;
   logic [1:0] flag_clr;

   assign flag_set = {door_trip, rej};
   assign flag_clr = (wr && (I_PADDR == `RSI_OFF_FLAG)) ? I_PWDATA[1:0] : 2'b00;

   // a new event in the clearing cycle is kept
   always_ff @(posedge I_CLK_SYS or negedge rst_n)
   begin
      if (!rst_n)
      begin
         flag <= `RSI_FLAG_RST;
      end
      else
      begin
         flag <= (flag & ~flag_clr) | flag_set;
      end
   end

   // ----------------------------------------
   // outputs
   // ----------------------------------------
   assign O_SERVO_ON = (state == rsi_pkg::ST_SERVO) || (state == rsi_pkg::ST_RUN);
   assign O_RUN = (state == rsi_pkg::ST_RUN);
   assign O_ERROR = (state == rsi_pkg::ST_FAULT);
   assign O_BRAKE_REL = brake_rel;
   assign O_JOG_EN = jog_en;
   assign O_MODE_AUTO = mode_auto;
   assign O_RIGHTS_EXT = rights_ext;
   assign O_RIGHTS_PEND = rights_pend;

   // ----------------------------------------
   // assertions
   // ----------------------------------------
   default clocking cb @(posedge I_CLK_SYS); endclocking
   default disable iff (!rst_n);

   sequence s_auto_door_open;
      O_SERVO_ON && mode_auto && !sw.door;
   endsequence
   sequence s_fault_entered;
      O_ERROR && !O_SERVO_ON && !O_RUN;
   endsequence
   property p_door_trip;
      s_auto_door_open |=> s_fault_entered ##1 O_ERROR;
   endproperty
   a_door_trip: assert property (p_door_trip) else $error("door trip missed");
   property p_endev_cut;
      (O_SERVO_ON && !mode_auto && !sw.door && !sw.endev) |=> !O_SERVO_ON;
   endproperty
   a_endev_cut: assert property (p_endev_cut) else $error("servo kept on");
   property p_refuse_brake;
      (!sw.door && !sw.endev) |=> !O_BRAKE_REL;
   endproperty
   a_refuse_brake: assert property (p_refuse_brake) else $error("brake granted");
   property p_pend_alone;
      (state == rsi_pkg::ST_OFF && cmd[`RSI_CMD_SON] && !cmd[`RSI_CMD_SRC] && !mode_auto &&
       sw.pend_act && sw.pend_sw && sw.door) |=> O_SERVO_ON;
   endproperty
   a_pend_alone: assert property (p_pend_alone) else $error("pendant servo on refused");
   // jog is registered, so the mode it was granted under is the one of the cycle before
   property p_jog_door;
      O_JOG_EN |-> $past(sw.endev || sw.door) && $past(sw.pend_sw) && $past(!mode_auto);
   endproperty
   a_jog_door: assert property (p_jog_door) else $error("jog without interlock");
   property p_brake;
      O_BRAKE_REL |-> $past(!mode_auto && sw.pend_act && sw.pend_sw && sw.endev);
   endproperty
   a_brake: assert property (p_brake) else $error("brake without switches");
   property p_run_auto;
      O_RUN |-> $past(mode_auto && sw.door && !sw.pend_act);
   endproperty
   a_run_auto: assert property (p_run_auto) else $error("run without auto permit");
   property p_rights;
      !(O_RIGHTS_EXT && O_RIGHTS_PEND) && (!O_RIGHTS_EXT || ctrl[`RSI_CTRL_EXT]);
   endproperty
   a_rights: assert property (p_rights) else $error("rights conflict");
   property p_key_auto;
      (sw.key1 && sw.key2) |=> O_MODE_AUTO;
   endproperty
   a_key_auto: assert property (p_key_auto) else $error("auto not selected");
   property p_key_hold;
      (sw.key1 != sw.key2) |=> $stable(O_MODE_AUTO);
   endproperty
   a_key_hold: assert property (p_key_hold) else $error("mode moved");

endmodule // rsi_interlock

// [rsi_map.svh]
// Purpose: named offsets, field positions, reset values and timing for the interlock
// Assumes: 32-bit apb data, byte addresses, 50 MHz system clock
// Notes: definitions only
`ifndef RSI_MAP_SVH
`define RSI_MAP_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define RSI_OFF_CTRL 8'h00
`define RSI_OFF_CMD 8'h04
`define RSI_OFF_STAT 8'h08
`define RSI_OFF_FLAG 8'h0c

// ----------------------------------------
// field positions
// ----------------------------------------
`define RSI_CTRL_EXT 0
`define RSI_CTRL_JOG 1
`define RSI_CTRL_BRK 2
`define RSI_CMD_SON 0
`define RSI_CMD_SOFF 1
`define RSI_CMD_ARST 2
`define RSI_CMD_START 3
`define RSI_CMD_STOP 4
`define RSI_CMD_SRC 5
`define RSI_FLAG_REJ 0
`define RSI_FLAG_TRIP 1

// ----------------------------------------
// reset values and timing
// ----------------------------------------
`define RSI_CTRL_RST 3'h0
`define RSI_FLAG_RST 2'h0
`define RSI_FLT_RST 1'b0
`define RSI_CLK_MHZ 50
`define RSI_FILT_US 1000
`define RSI_FILT_CYC (`RSI_FILT_US * `RSI_CLK_MHZ)
`define RSI_FLT_CW 16

`endif

// [rsi_pkg.sv]
// Purpose: types shared by the interlock files
// Assumes: nothing
// Notes: switch bits are 1 when the contact is closed
package rsi_pkg;

   typedef enum logic [1:0]
   {
      ST_OFF = 2'b00,
      ST_SERVO = 2'b01,
      ST_RUN = 2'b10,
      ST_FAULT = 2'b11
   } rsi_state_t;

   typedef struct packed
   {
      logic key2;
      logic key1;
      logic pend_act;
      logic pend_sw;
      logic endev;
      logic door;
   } rsi_sw_t;

   typedef struct packed
   {
      logic [19:0] zero;
      rsi_sw_t sw;
      logic brake;
      logic jog;
      logic err;
      logic auto_mode;
      rsi_state_t state;
   } rsi_stat_t;

endpackage

// [rsi_filter.sv]
// Purpose: per-bit two-flop synchroniser and stability filter for contact inputs
// Assumes: raw inputs are asynchronous contact closures
// Notes: a bit changes only after holding its new level for CNT cycles
`include "rsi_map.svh"

module rsi_filter #(
   parameter int N = 6,
   parameter int CNT = `RSI_FILT_CYC
)(
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [N-1:0] i_raw,
   output logic [N-1:0] o_flt
);

   genvar g;
   generate
      for (g = 0; g < N; g++)
      begin : g_bit
         logic s1;
         logic s2;
         logic [`RSI_FLT_CW-1:0] cnt;

         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               s1 <= `RSI_FLT_RST;
               s2 <= `RSI_FLT_RST;
            end
            else
            begin
               s1 <= i_raw[g];
               s2 <= s1;
            end
         end

         // open contact at reset is the safe reading
         always_ff @(posedge i_clk or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               cnt <= '0;
               o_flt[g] <= `RSI_FLT_RST;
            end
            else if (s2 == o_flt[g])
            begin
               cnt <= '0;
            end
            else if (cnt == `RSI_FLT_CW'(CNT - 1))
            begin
               cnt <= '0;
               o_flt[g] <= s2;
            end
            else
            begin
               cnt <= cnt + 1'b1;
            end
         end
      end
   endgenerate

endmodule // rsi_filter

// [rsi_partner.sv]
// Purpose: contact model for door, enabling device, pendant and key switch
// Assumes: every contact is a level, 1 when closed
// Notes: a bounce request adds chatter that is shorter than the input filter

module rsi_partner
(
   input wire logic i_clk,
   input wire rsi_pkg::rsi_sw_t i_want,
   input wire logic i_bounce,
   output rsi_pkg::rsi_sw_t o_sw
);
   timeunit 1ns;
   timeprecision 1ps;

   rsi_pkg::rsi_sw_t last;
   rsi_pkg::rsi_sw_t prev;
   logic [1:0] chat;

   initial
   begin
      o_sw = '0;
      last = '0;
      prev = '0;
      chat = 2'h0;
   end

   // ----------------------------------------
   // contact chatter
   // ----------------------------------------
   // a real contact bounces: new level one cycle, old level one cycle, then settled
   always @(posedge i_clk)
   begin
      if (i_want != last)
      begin
         prev <= o_sw;
         last <= i_want;
         o_sw <= i_want;
         chat <= i_bounce ? 2'h2 : 2'h0;
      end
      else if (chat == 2'h2)
      begin
         o_sw <= prev;
         chat <= 2'h1;
      end
      else
      begin
         o_sw <= last;
         chat <= 2'h0;
      end
   end
endmodule // rsi_partner

// [test_robot_safety_interlock.sv]
// Purpose: self-checking bench for the interlock against a behavioural model
// Assumes: filter shortened to four cycles; apb slave answers without wait states
// Notes: outputs are compared once the contacts have settled

module test_robot_safety_interlock;
   timeunit 1ns;
   timeprecision 1ps;

   localparam int FILT = 4;
   localparam int SETTLE = FILT + 8;
   localparam int LIMIT = 6000;

   logic clk, rst_n, psel, penable, pwrite, bounce, re;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rq, seed;
   logic pready, pslverr, servo, brake, jog, run, err, auto_m, r_ext, r_pend;
   rsi_pkg::rsi_sw_t want, sw;
   int failures, n_tests, cycles, m_auto, m_state, m_ctrl, m_flag;

   rsi_partner u_sw (.i_clk(clk), .i_want(want), .i_bounce(bounce), .o_sw(sw));

   rsi_interlock #(.P_FILT_CYC(FILT)) dut (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_DOOR_CLOSED(sw.door), .I_ENDEV_CLOSED(sw.endev),
      .I_PEND_SW_ON(sw.pend_sw), .I_PEND_ACTIVE(sw.pend_act), .I_KEY1_CLOSED(sw.key1),
      .I_KEY2_CLOSED(sw.key2), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
      .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
      .O_SERVO_ON(servo), .O_BRAKE_REL(brake), .O_JOG_EN(jog), .O_RUN(run), .O_ERROR(err),
      .O_MODE_AUTO(auto_m), .O_RIGHTS_EXT(r_ext), .O_RIGHTS_PEND(r_pend));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic logic perm();
      if (m_auto != 0)
         return !want.pend_act && want.door;
      return want.pend_act && want.pend_sw && (want.endev || want.door);
   endfunction

   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("BAD %0t check %0d got %h expected %h", $time, n_tests, got, exp);
      end
   endtask

   // holds the request until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      cmp(n, 1); // slave answers in the first access cycle
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rq, re);
      cmp(re, 1'b0);
   endtask

   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input logic e_exp);
      apb(1'b0, a, 32'h0, rq, re);
      cmp(rq, exp);
      cmp(re, e_exp);
   endtask

   task automatic chk_out;
      logic xj, xb;
      repeat (2) @(posedge clk);
      @(negedge clk);
      xj = m_ctrl[1] && m_state == 1 && m_auto == 0 && perm();
      xb = m_ctrl[2] && m_auto == 0 && want.pend_act && want.pend_sw && want.endev;
      cmp(servo, m_state == 1 || m_state == 2);
      cmp(run, m_state == 2);
      cmp(err, m_state == 3);
      cmp(jog, xj);
      cmp(brake, xb);
      cmp(auto_m, m_auto != 0);
      cmp(r_ext, m_auto != 0 && m_ctrl[0]);
      cmp(r_pend, m_auto == 0 && want.pend_act);
      rd_chk(8'h08, {20'h0, want, xb, xj, m_state == 3, m_auto[0], m_state[1:0]}, 1'b0);
   endtask

   task automatic set_sw(input logic [5:0] v, input logic b);
      want <= v;
      bounce <= b;
      repeat (SETTLE) @(posedge clk);
      if (v[5] == v[4])
         m_auto = v[5];
      if (m_auto != 0 && !v[0] && (m_state == 1 || m_state == 2))
      begin
         m_state = 3;
         m_flag = m_flag | 2;
      end
      else if ((m_state == 1 || m_state == 2) && !perm())
         m_state = 0;
      chk_out();
   endtask

   // commands: 0 servo on, 1 servo off, 2 alarm reset, 3 start, 4 stop; src 1 is external
   task automatic cmd(input int b, input int src);
      logic ok;
      wr(8'h04, (32'h1 << b) | (32'(src) << 5));
      ok = (src != 0) ? (m_auto != 0 && m_ctrl[0]) : (m_auto == 0 && want.pend_act);
      // only a refused source, servo-on without permit or reset with the door open flags
      if (!ok)
         m_flag = m_flag | 1;
      else
         case (b)
            0: if (m_state == 0 && perm()) m_state = 1; else if (m_state == 0) m_flag = m_flag | 1;
            1: if (m_state == 1 || m_state == 2) m_state = 0;
            2: if (m_state == 3 && want.door) m_state = 0; else if (m_state == 3) m_flag = m_flag | 1;
            3: if (m_auto != 0 && m_state == 1) m_state = 2;
            default: if (m_state == 2) m_state = 1;
         endcase
      chk_out();
   endtask

   task automatic chk_flag;
      rd_chk(8'h0c, m_flag, 1'b0);
      wr(8'h0c, 32'h3);
      m_flag = 0;
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles == LIMIT)
      begin
         failures++;
         $display("BAD %0t run did not finish", $time);
         end_sim();
      end
   end

   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial
   begin
      {rst_n, psel, penable, pwrite, bounce, paddr, pwdata} = '0;
      want = '0;
      {failures, n_tests, cycles, m_auto, m_state, m_ctrl, m_flag} = '0;
      seed = 32'h00000033;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(8'h00, 32'h0, 1'b0);
      rd_chk(8'h04, 32'h0, 1'b0);
      chk_flag();
      seed = xs(seed);
      apb(1'b1, 8'h10, seed, rq, re);
      cmp(re, 1'b1);
      rd_chk(8'h10, 32'h0, 1'b1);
      seed = xs(seed);
      wr(8'h00, seed);
      m_ctrl = int'(seed[2:0]);
      rd_chk(8'h00, m_ctrl, 1'b0);
      // key lines with chatter, then disagreeing lines
      set_sw(6'b110001, 1'b1);
      set_sw(6'b100001, 1'b0);
      set_sw(6'b000001, 1'b1);
      set_sw(6'b010001, 1'b0);
      // teaching with the door open
      wr(8'h00, 32'h6);
      m_ctrl = 6;
      set_sw(6'b001110, 1'b0);
      cmd(0, 0);
      set_sw(6'b001100, 1'b1);
      cmd(0, 0);
      chk_flag();
      set_sw(6'b001010, 1'b0);
      // door closed, enabling device open
      set_sw(6'b001101, 1'b0);
      cmd(0, 0);
      cmd(0, 1);
      chk_flag();
      cmd(1, 0);
      // automatic operation
      set_sw(6'b000001, 1'b0);
      set_sw(6'b110001, 1'b0);
      wr(8'h00, 32'h0);
      m_ctrl = 0;
      cmd(0, 1);
      cmd(0, 0);
      chk_flag();
      wr(8'h00, 32'h1);
      m_ctrl = 1;
      cmd(0, 1);
      cmd(3, 1);
      cmd(4, 1);
      cmd(3, 1);
      set_sw(6'b110000, 1'b0);
      cmd(2, 1);
      chk_flag();
      // operator recovery: close door, reset alarm, servo on, restart
      set_sw(6'b110001, 1'b0);
      cmd(2, 1);
      cmd(0, 1);
      cmd(3, 1);
      set_sw(6'b111001, 1'b0);
      chk_flag();
      end_sim();
   end
endmodule // test_robot_safety_interlock
